// File: logic/alu_defs.svh
// constants for the arithmetic and logic datapath
// assumes status bit positions follow the core's status register layout
`ifndef ALU_DEFS_SVH
`define ALU_DEFS_SVH

// status register bit positions
`define ALU_FLAG_C        0
`define ALU_FLAG_Z        1
`define ALU_FLAG_N        2
`define ALU_FLAG_V        3
`define ALU_FLAG_S        4
`define ALU_FLAG_H        5

// flag update masks, bit order {H,S,V,N,Z,C}
`define ALU_MASK_ZCNVH    6'h2f
`define ALU_MASK_ZCNVS    6'h1f
`define ALU_MASK_ZCNV     6'h0f
`define ALU_MASK_ZNV      6'h0e
`define ALU_MASK_ZC       6'h03

// operand constants
`define ALU_ALL_ONES      8'hff
`define ALU_ZERO_BYTE     8'h00
`define ALU_ONE_BYTE      8'h01

// reset values
`define ALU_RESET_RESULT  16'h0000
`define ALU_RESET_STATUS  8'h00

// cycles from take to answer
`define ALU_CYC_SINGLE    1
`define ALU_CYC_DOUBLE    2

`endif

// File: logic/alu_pkg.sv
// types for the arithmetic and logic datapath
// assumes the decoder encodes operations as alu_op_t
package alu_pkg;

   typedef enum logic [4:0] {
      ALU_OP_SUM,
      ALU_OP_SUM_CARRY,
      ALU_OP_WORD_IMMEDIATE_SUM,
      ALU_OP_DIFFERENCE,
      ALU_OP_CONSTANT_DIFFERENCE,
      ALU_OP_DIFFERENCE_WITH_BORROW,
      ALU_OP_CONSTANT_DIFFERENCE_BORROW,
      ALU_OP_WORD_IMMEDIATE_DIFFERENCE,
      ALU_OP_CONJUNCTION,
      ALU_OP_CONJUNCTION_CONSTANT,
      ALU_OP_UNION,
      ALU_OP_UNION_CONSTANT,
      ALU_OP_BITWISE_EXCLUSIVE_UNION,
      ALU_OP_BITWISE_INVERT,
      ALU_OP_TWOS_INVERSE,
      ALU_OP_BIT_SET_MASK,
      ALU_OP_BIT_CLEAR_MASK,
      ALU_OP_PLUS_ONE,
      ALU_OP_MINUS_ONE,
      ALU_OP_ZERO_SIGN_CHECK,
      ALU_OP_UNSIGNED_PRODUCT,
      ALU_OP_SIGNED_PRODUCT,
      ALU_OP_MIXED_SIGN_PRODUCT,
      ALU_OP_FRACTION_PRODUCT_UNSIGNED
   } alu_op_t;

   typedef enum logic {
      ALU_ST_IDLE,
      ALU_ST_SECOND
   } alu_state_t;

   typedef struct packed {
      alu_state_t  state;
      logic        busy;
      logic        done;
      logic        wr_byte;
      logic        wr_word;
      logic        wr_prod;
      logic [15:0] result;
      logic [7:0]  status;
      logic        p_word;
      logic        p_prod;
      logic [15:0] p_result;
      logic [7:0]  p_status;
   } alu_regs_t;

endpackage

// File: logic/alu_core.sv
// arithmetic and logic datapath of the 8-bit core
// assumes the decoder presents operands and a one-cycle start strobe,
// and writes back result and status when done_o pulses
`include "alu_defs.svh"

// Behaviour
// - sum and sum-with-carry write Rd+Rr(+C) to Rd, one cycle, Z C N V H.
// - word immediate sum adds constant to pair, two cycles, Z C N V S.
// - difference and constant difference write Rd-Rr or Rd-K, one cycle, Z C N V H.
// - borrow differences also subtract carry, one cycle, Z C N V H.
// - word immediate difference subtracts constant from pair, one cycle, Z C N V S.
// - conjunction with register or constant stores AND, one cycle, Z N V.
// - union with register or constant stores OR, one cycle, Z N V.
// - exclusive union stores XOR of Rd and Rr, one cycle, Z N V.
// - invert gives FF-Rd with Z C N V; twos inverse gives 00-Rd with H too.
// - bit set ORs mask in, bit clear ANDs with inverted mask, Z N V.
// - plus-one, minus-one change Rd by one; check ANDs Rd with itself; Z N V.
// - unsigned, signed, mixed products put 16-bit product in R1:R0, two cycles, Z C.
// - fractional unsigned product shifts product left one bit, two cycles, Z C.
module alu_core (
   // clock and reset
   input  wire logic             clock_i,
   input  wire logic             nrst_i,
   // request
   input  wire logic             start_i,
   input  wire alu_pkg::alu_op_t op_i,
   input  wire logic [7:0]       rd_i,
   input  wire logic [7:0]       rdh_i,
   input  wire logic [7:0]       rr_i,
   input  wire logic [7:0]       k_i,
   input  wire logic [7:0]       status_i,
   // answer
   output logic                  busy_o,
   output logic                  done_o,
   output logic                  write_byte_o,
   output logic                  write_word_o,
   output logic                  write_product_o,
   output logic [15:0]           result_o,
   output logic [7:0]            status_o
);

   alu_pkg::alu_regs_t q_reg;
   alu_pkg::alu_regs_t q_next;

   // returns {h, v, c, r[7:0]}; subtract takes ci as borrow
   function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b,
                                        input logic ci, input logic subtract);
      logic [8:0] full;
      logic [4:0] half;
      logic       v;
      if (subtract) begin
         full = {1'b0, a} - {1'b0, b} - {8'h00, ci};
         half = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
         v    = (a[7] != b[7]) && (full[7] != a[7]);
      end else begin
         full = {1'b0, a} + {1'b0, b} + {8'h00, ci};
         half = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
         v    = (a[7] == b[7]) && (full[7] != a[7]);
      end
      return {half[4], v, full[8], full[7:0]};
   endfunction

   always_comb begin
      logic [10:0] ar;
      logic [16:0] wide;
      logic [15:0] prod;
      logic [15:0] res;
      logic [5:0]  mask;
      logic [7:0]  st;
      logic        z;
      logic        c;
      logic        n;
      logic        v;
      logic        h;
      logic        is_word;
      logic        is_prod;
      logic        two;
      ar      = 11'h000;
      wide    = 17'h00000;
      prod    = 16'h0000;
      res     = 16'h0000;
      mask    = 6'h00;
      st      = status_i;
      z       = 1'b0;
      c       = 1'b0;
      n       = 1'b0;
      v       = 1'b0;
      h       = 1'b0;
      is_word = 1'b0;
      is_prod = 1'b0;
      two     = 1'b0;
      q_next  = q_reg;
      q_next.done    = 1'b0;
      q_next.wr_byte = 1'b0;
      q_next.wr_word = 1'b0;
      q_next.wr_prod = 1'b0;

      case (op_i)
         alu_pkg::ALU_OP_SUM,
         alu_pkg::ALU_OP_SUM_CARRY: begin
            ar   = add8(rd_i, rr_i, (op_i == alu_pkg::ALU_OP_SUM_CARRY) && status_i[`ALU_FLAG_C], 1'b0);
            mask = `ALU_MASK_ZCNVH;
         end
         alu_pkg::ALU_OP_DIFFERENCE: begin
            ar   = add8(rd_i, rr_i, 1'b0, 1'b1);
            mask = `ALU_MASK_ZCNVH;
         end
         alu_pkg::ALU_OP_CONSTANT_DIFFERENCE: begin
            ar   = add8(rd_i, k_i, 1'b0, 1'b1);
            mask = `ALU_MASK_ZCNVH;
         end
         alu_pkg::ALU_OP_DIFFERENCE_WITH_BORROW: begin
            ar   = add8(rd_i, rr_i, status_i[`ALU_FLAG_C], 1'b1);
            mask = `ALU_MASK_ZCNVH;
         end
         alu_pkg::ALU_OP_CONSTANT_DIFFERENCE_BORROW: begin
            ar   = add8(rd_i, k_i, status_i[`ALU_FLAG_C], 1'b1);
            mask = `ALU_MASK_ZCNVH;
         end
         alu_pkg::ALU_OP_WORD_IMMEDIATE_SUM: begin
            wide    = {1'b0, rdh_i, rd_i} + {9'h000, k_i};
            is_word = 1'b1;
            two     = 1'b1;
            mask    = `ALU_MASK_ZCNVS;
         end
         alu_pkg::ALU_OP_WORD_IMMEDIATE_DIFFERENCE: begin
            wide    = {1'b0, rdh_i, rd_i} - {9'h000, k_i};
            is_word = 1'b1;
            mask    = `ALU_MASK_ZCNVS;
         end
         alu_pkg::ALU_OP_CONJUNCTION: begin
            ar   = {3'b000, rd_i & rr_i};
            mask = `ALU_MASK_ZNV;
         end
         alu_pkg::ALU_OP_CONJUNCTION_CONSTANT: begin
            ar   = {3'b000, rd_i & k_i};
            mask = `ALU_MASK_ZNV;
         end
         alu_pkg::ALU_OP_UNION: begin
            ar   = {3'b000, rd_i | rr_i};
            mask = `ALU_MASK_ZNV;
         end
         alu_pkg::ALU_OP_UNION_CONSTANT: begin
            ar   = {3'b000, rd_i | k_i};
            mask = `ALU_MASK_ZNV;
         end
         alu_pkg::ALU_OP_BITWISE_EXCLUSIVE_UNION: begin
            ar   = {3'b000, rd_i ^ rr_i};
            mask = `ALU_MASK_ZNV;
         end
         alu_pkg::ALU_OP_BITWISE_INVERT: begin
            // carry is always set, overflow always cleared
            ar   = {3'b001, `ALU_ALL_ONES - rd_i};
            mask = `ALU_MASK_ZCNV;
         end
         alu_pkg::ALU_OP_TWOS_INVERSE: begin
            ar   = add8(`ALU_ZERO_BYTE, rd_i, 1'b0, 1'b1);
            mask = `ALU_MASK_ZCNVH;
         end
         alu_pkg::ALU_OP_BIT_SET_MASK: begin
            ar   = {3'b000, rd_i | k_i};
            mask = `ALU_MASK_ZNV;
         end
         alu_pkg::ALU_OP_BIT_CLEAR_MASK: begin
            ar   = {3'b000, rd_i & (`ALU_ALL_ONES - k_i)};
            mask = `ALU_MASK_ZNV;
         end
         alu_pkg::ALU_OP_PLUS_ONE: begin
            ar   = add8(rd_i, `ALU_ONE_BYTE, 1'b0, 1'b0);
            mask = `ALU_MASK_ZNV;
         end
         alu_pkg::ALU_OP_MINUS_ONE: begin
            ar   = add8(rd_i, `ALU_ONE_BYTE, 1'b0, 1'b1);
            mask = `ALU_MASK_ZNV;
         end
         alu_pkg::ALU_OP_ZERO_SIGN_CHECK: begin
            ar   = {3'b000, rd_i & rd_i};
            mask = `ALU_MASK_ZNV;
         end
         alu_pkg::ALU_OP_UNSIGNED_PRODUCT,
         alu_pkg::ALU_OP_FRACTION_PRODUCT_UNSIGNED: begin
            prod = {8'h00, rd_i} * {8'h00, rr_i};
         end
         alu_pkg::ALU_OP_SIGNED_PRODUCT: begin
            // low half of a sign-extended product equals the signed product
            prod = {{8{rd_i[7]}}, rd_i} * {{8{rr_i[7]}}, rr_i};
         end
         alu_pkg::ALU_OP_MIXED_SIGN_PRODUCT: begin
            prod = {{8{rd_i[7]}}, rd_i} * {8'h00, rr_i};
         end
         default: begin
            mask = 6'h00;
         end
      endcase

      is_prod = (op_i == alu_pkg::ALU_OP_UNSIGNED_PRODUCT) || (op_i == alu_pkg::ALU_OP_SIGNED_PRODUCT)
             || (op_i == alu_pkg::ALU_OP_MIXED_SIGN_PRODUCT) || (op_i == alu_pkg::ALU_OP_FRACTION_PRODUCT_UNSIGNED);

      if (is_prod) begin
         two  = 1'b1;
         mask = `ALU_MASK_ZC;
         c    = prod[15];
         // carry keeps the unshifted top bit
         res  = (op_i == alu_pkg::ALU_OP_FRACTION_PRODUCT_UNSIGNED) ? {prod[14:0], 1'b0} : prod;
         z    = (res == 16'h0000);
      end else if (is_word) begin
         res = wide[15:0];
         z   = (res == 16'h0000);
         n   = res[15];
         c   = wide[16];
         v   = (op_i == alu_pkg::ALU_OP_WORD_IMMEDIATE_SUM) ? (!rdh_i[7] && res[15]) : (rdh_i[7] && !res[15]);
      end else begin
         res = {8'h00, ar[7:0]};
         z   = (ar[7:0] == `ALU_ZERO_BYTE);
         n   = ar[7];
         c   = ar[8];
         v   = ar[9];
         h   = ar[10];
      end

      if (mask[`ALU_FLAG_C]) st[`ALU_FLAG_C] = c;
      if (mask[`ALU_FLAG_Z]) st[`ALU_FLAG_Z] = z;
      if (mask[`ALU_FLAG_N]) st[`ALU_FLAG_N] = n;
      if (mask[`ALU_FLAG_V]) st[`ALU_FLAG_V] = v;
      if (mask[`ALU_FLAG_S]) st[`ALU_FLAG_S] = n ^ v;
      if (mask[`ALU_FLAG_H]) st[`ALU_FLAG_H] = h;

      case (q_reg.state)
         alu_pkg::ALU_ST_IDLE: begin
            if (start_i) begin
               if (two) begin
                  // second cycle delivers; no new request is taken meanwhile
                  q_next.state    = alu_pkg::ALU_ST_SECOND;
                  q_next.busy     = 1'b1;
                  q_next.p_word   = is_word;
                  q_next.p_prod   = is_prod;
                  q_next.p_result = res;
                  q_next.p_status = st;
               end else begin
                  q_next.done    = 1'b1;
                  // unknown codes answer with done only, so no stale byte lands in Rd
                  q_next.wr_byte = !is_word && (mask != 6'h00) && (op_i != alu_pkg::ALU_OP_ZERO_SIGN_CHECK);
                  q_next.wr_word = is_word;
                  q_next.result  = res;
                  q_next.status  = st;
               end
            end
         end
         alu_pkg::ALU_ST_SECOND: begin
            q_next.state   = alu_pkg::ALU_ST_IDLE;
            q_next.busy    = 1'b0;
            q_next.done    = 1'b1;
            q_next.wr_word = q_reg.p_word;
            q_next.wr_prod = q_reg.p_prod;
            q_next.result  = q_reg.p_result;
            q_next.status  = q_reg.p_status;
         end
         default: begin
            q_next.state = alu_pkg::ALU_ST_IDLE;
            q_next.busy  = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         q_reg.state    <= alu_pkg::ALU_ST_IDLE;
         q_reg.busy     <= 1'b0;
         q_reg.done     <= 1'b0;
         q_reg.wr_byte  <= 1'b0;
         q_reg.wr_word  <= 1'b0;
         q_reg.wr_prod  <= 1'b0;
         q_reg.result   <= `ALU_RESET_RESULT;
         q_reg.status   <= `ALU_RESET_STATUS;
         q_reg.p_word   <= 1'b0;
         q_reg.p_prod   <= 1'b0;
         q_reg.p_result <= `ALU_RESET_RESULT;
         q_reg.p_status <= `ALU_RESET_STATUS;
      end else begin
         q_reg <= q_next;
      end
   end

   assign busy_o          = q_reg.busy;
   assign done_o          = q_reg.done;
   assign write_byte_o    = q_reg.wr_byte;
   assign write_word_o    = q_reg.wr_word;
   assign write_product_o = q_reg.wr_prod;
   assign result_o        = q_reg.result;
   assign status_o        = q_reg.status;

endmodule

// File: dv/alu_checker.sv
// concurrent checks for the arithmetic and logic datapath
// assumes it is bound to alu_core and sees only that module's ports
`include "alu_defs.svh"

module alu_checker (
   // clock and reset
   input wire logic             clock_i,
   input wire logic             nrst_i,
   // request
   input wire logic             start_i,
   input wire alu_pkg::alu_op_t op_i,
   input wire logic [7:0]       rd_i,
   input wire logic [7:0]       rdh_i,
   input wire logic [7:0]       rr_i,
   input wire logic [7:0]       k_i,
   input wire logic [7:0]       status_i,
   // answer
   input wire logic             busy_o,
   input wire logic             done_o,
   input wire logic             write_byte_o,
   input wire logic             write_word_o,
   input wire logic             write_product_o,
   input wire logic [15:0]      result_o,
   input wire logic [7:0]       status_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic take;
   logic prod;
   logic wsum;
   logic fast;
   logic any_wr;

   // unknown codes are left out of the latency checks on purpose
   assign take   = start_i && !busy_o;
   assign prod   = (op_i >= alu_pkg::ALU_OP_UNSIGNED_PRODUCT) && (op_i <= alu_pkg::ALU_OP_FRACTION_PRODUCT_UNSIGNED);
   assign wsum   = op_i == alu_pkg::ALU_OP_WORD_IMMEDIATE_SUM;
   assign fast   = (op_i <= alu_pkg::ALU_OP_ZERO_SIGN_CHECK) && !wsum;
   assign any_wr = write_byte_o || write_word_o || write_product_o;

   default clocking @(posedge clock_i);
   endclocking
   default disable iff (!nrst_i);

   sequence s_fast_answer;
      done_o && !busy_o;
   endsequence

   sequence s_slow_answer;
      busy_o && !done_o ##1 !busy_o && done_o;
   endsequence

   fast_answer_a: assert property (take && fast |=> s_fast_answer)
      else $error("single op answer not one cycle later");
   slow_answer_a: assert property (take && (prod || wsum) |=> s_slow_answer)
      else $error("two cycle op answer out of step");
   busy_single_a: assert property (busy_o |=> !busy_o)
      else $error("busy held longer than one cycle");
   write_done_a: assert property (any_wr |-> done_o && $onehot({write_byte_o, write_word_o, write_product_o}))
      else $error("write strobe without done or more than one");
   hold_output_a: assert property (!done_o |-> $stable(result_o) && $stable(status_o))
      else $error("result changed without done");
   sum_value_a: assert property (take && op_i == alu_pkg::ALU_OP_SUM |=>
      result_o == {8'h00, 8'($past(rd_i) + $past(rr_i))} && write_byte_o)
      else $error("sum result wrong");
   word_sum_a: assert property (take && wsum |-> ##2 write_word_o &&
      result_o == {$past(rdh_i, 2), $past(rd_i, 2)} + {8'h00, $past(k_i, 2)})
      else $error("word sum result wrong");
   product_a: assert property (take && op_i == alu_pkg::ALU_OP_UNSIGNED_PRODUCT |-> ##2 write_product_o &&
      result_o == 16'($past(rd_i, 2)) * 16'($past(rr_i, 2)))
      else $error("unsigned product wrong");
   zero_flag_a: assert property (any_wr |-> status_o[`ALU_FLAG_Z] == (result_o == 16'h0000))
      else $error("zero flag wrong");
   neg_flag_a: assert property (write_byte_o |-> status_o[`ALU_FLAG_N] == result_o[7])
      else $error("negative flag wrong");
   word_sign_a: assert property (write_word_o |-> status_o[`ALU_FLAG_N] == result_o[15] &&
      status_o[`ALU_FLAG_S] == (status_o[`ALU_FLAG_N] ^ status_o[`ALU_FLAG_V]))
      else $error("word sign flag wrong");
endmodule

bind alu_core alu_checker i_chk (.clock_i, .nrst_i, .start_i, .op_i, .rd_i, .rdh_i, .rr_i, .k_i, .status_i,
   .busy_o, .done_o, .write_byte_o, .write_word_o, .write_product_o, .result_o, .status_o);

// File: dv/cpu_arith_logic_unit_tb.sv
// self-checking bench for the arithmetic and logic datapath
// assumes alu_core and its bound checker are compiled before it
module cpu_arith_logic_unit_tb;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic [7:0]  rd, rdh, rr, k, st;
      logic [15:0] res;
      logic [7:0]  sto;
      logic [2:0]  wr;
   } alu_row_t;

   logic             clock_i;
   logic             nrst_i;
   logic             start_i;
   alu_pkg::alu_op_t op_i;
   logic [7:0]       rd_i, rdh_i, rr_i, k_i, status_i;
   logic             busy_o, done_o;
   logic             write_byte_o, write_word_o, write_product_o;
   logic [15:0]      result_o;
   logic [7:0]       status_o;
   logic [4:0]       strobes;
   alu_row_t         rows [24];
   int               n_errors;
   int               checks_done;
   int               lat;

   assign strobes = {busy_o, done_o, write_product_o, write_word_o, write_byte_o};

   alu_core i_dut (.clock_i, .nrst_i, .start_i, .op_i, .rd_i, .rdh_i, .rr_i, .k_i, .status_i,
      .busy_o, .done_o, .write_byte_o, .write_word_o, .write_product_o, .result_o, .status_o);

   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask

   task automatic drive(input alu_pkg::alu_op_t op, input alu_row_t r);
      op_i     = op;
      rd_i     = r.rd;
      rdh_i    = r.rdh;
      rr_i     = r.rr;
      k_i      = r.k;
      status_i = r.st;
      start_i  = 1'b1;
   endtask

   // bounded wait: a lost done shows up as a latency mismatch
   task automatic issue(input alu_pkg::alu_op_t op, input alu_row_t r);
      drive(op, r);
      @(posedge clock_i);
      #1 start_i = 1'b0;
      lat = 1;
      while (done_o !== 1'b1 && lat < 4) begin
         @(posedge clock_i);
         #1 lat++;
      end
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      repeat (1000) @(posedge clock_i);
      n_errors++;
      end_of_test();
   end

   initial begin
      // rd, rdh, rr, k, status in, result, status out, writes {product, word, byte}; row index is the op
      rows = '{'{8'h08, 8'h0, 8'h08, 8'h0, 8'h00, 16'h0010, 8'h20, 3'h1},
               '{8'hff, 8'h0, 8'h00, 8'h0, 8'h01, 16'h0000, 8'h23, 3'h1},
               '{8'hff, 8'h7f, 8'h0, 8'h01, 8'h00, 16'h8000, 8'h0c, 3'h2},
               '{8'h10, 8'h0, 8'h01, 8'h0, 8'h00, 16'h000f, 8'h20, 3'h1},
               '{8'h00, 8'h0, 8'h0, 8'h01, 8'h00, 16'h00ff, 8'h25, 3'h1},
               '{8'h80, 8'h0, 8'h00, 8'h0, 8'h01, 16'h007f, 8'h28, 3'h1},
               '{8'h05, 8'h0, 8'h0, 8'h05, 8'h01, 16'h00ff, 8'h25, 3'h1},
               '{8'h00, 8'h00, 8'h0, 8'h01, 8'h00, 16'hffff, 8'h15, 3'h2},
               '{8'hf0, 8'h0, 8'h0f, 8'h0, 8'h01, 16'h0000, 8'h03, 3'h1},
               '{8'hf0, 8'h0, 8'h0, 8'h80, 8'h08, 16'h0080, 8'h04, 3'h1},
               '{8'h00, 8'h0, 8'h00, 8'h0, 8'h00, 16'h0000, 8'h02, 3'h1},
               '{8'h01, 8'h0, 8'h0, 8'h80, 8'h00, 16'h0081, 8'h04, 3'h1},
               '{8'hff, 8'h0, 8'h0f, 8'h0, 8'h00, 16'h00f0, 8'h04, 3'h1},
               '{8'hff, 8'h0, 8'h0, 8'h0, 8'h00, 16'h0000, 8'h03, 3'h1},
               '{8'h80, 8'h0, 8'h0, 8'h0, 8'h00, 16'h0080, 8'h0d, 3'h1},
               '{8'h00, 8'h0, 8'h0, 8'h01, 8'h00, 16'h0001, 8'h00, 3'h1},
               '{8'hff, 8'h0, 8'h0, 8'h0f, 8'h00, 16'h00f0, 8'h04, 3'h1},
               '{8'h7f, 8'h0, 8'h0, 8'h0, 8'h21, 16'h0080, 8'h2d, 3'h1},
               '{8'h80, 8'h0, 8'h0, 8'h0, 8'h00, 16'h007f, 8'h08, 3'h1},
               '{8'h00, 8'h0, 8'h0, 8'h0, 8'h08, 16'h0000, 8'h02, 3'h0},
               '{8'hff, 8'h0, 8'hff, 8'h0, 8'h00, 16'hfe01, 8'h01, 3'h4},
               '{8'hff, 8'h0, 8'h02, 8'h0, 8'h00, 16'hfffe, 8'h01, 3'h4},
               '{8'hff, 8'h0, 8'hff, 8'h0, 8'h00, 16'hff01, 8'h01, 3'h4},
               '{8'h80, 8'h0, 8'h80, 8'h0, 8'h00, 16'h8000, 8'h00, 3'h4}};
      nrst_i  = 1'b0;
      start_i = 1'b0;
      op_i    = alu_pkg::ALU_OP_SUM;
      {rd_i, rdh_i, rr_i, k_i, status_i} = '0;
      repeat (10) @(posedge clock_i);
      cmp(16'(strobes) | result_o | 16'(status_o), 16'h0, "in reset");
      #1 nrst_i = 1'b1;
      for (int i = 0; i < 24; i++) begin
         issue(alu_pkg::alu_op_t'(i), rows[i]);
         cmp(16'(lat), (rows[i].wr[2] || i == 2) ? 16'h2 : 16'h1, "latency");
         cmp(result_o, rows[i].res, "result");
         cmp(16'(status_o), 16'(rows[i].sto), "status");
         cmp(16'(strobes), 16'({2'b01, rows[i].wr}), "strobes");
         $display("row %0d done", i);
         // one idle edge so the strobe is not lowered and raised in one step
         @(posedge clock_i);
         #1;
      end
      // back to back single ops, carry taken from the second status
      drive(alu_pkg::ALU_OP_SUM, rows[0]);
      @(posedge clock_i);
      #1 drive(alu_pkg::ALU_OP_SUM_CARRY, rows[1]);
      cmp(result_o, 16'h0010, "first of pair");
      @(posedge clock_i);
      #1 start_i = 1'b0;
      cmp({result_o[7:0], status_o}, 16'h0023, "second of pair");
      $display("back to back done");
      // a request while busy is dropped
      @(posedge clock_i);
      #1 drive(alu_pkg::ALU_OP_UNSIGNED_PRODUCT, rows[20]);
      @(posedge clock_i);
      #1 drive(alu_pkg::ALU_OP_SUM, rows[0]);
      @(posedge clock_i);
      #1 start_i = 1'b0;
      cmp(result_o, 16'hfe01, "product kept");
      @(posedge clock_i);
      #1 cmp(16'(strobes), 16'h0, "busy request dropped");
      $display("busy refusal done");
      issue(alu_pkg::alu_op_t'(5'h1f), rows[0]);
      cmp(16'(strobes), 16'h08, "unknown op");
      $display("unknown op done");
      // reset in the middle of a two cycle op
      drive(alu_pkg::ALU_OP_SIGNED_PRODUCT, rows[21]);
      @(posedge clock_i);
      #1 start_i = 1'b0;
      nrst_i = 1'b0;
      #1 cmp(16'(strobes) | result_o, 16'h0, "mid reset");
      @(posedge clock_i);
      #1 nrst_i = 1'b1;
      @(posedge clock_i);
      #1 cmp(16'(strobes), 16'h0, "after reset");
      issue(alu_pkg::ALU_OP_FRACTION_PRODUCT_UNSIGNED, rows[23]);
      cmp(result_o, 16'h8000, "after reset op");
      $display("mid reset done");
      end_of_test();
   end
endmodule
